//--- rtl/rtc_map_regs.svh
// register offsets, field positions, reset values and constants of the tick counter
`ifndef RTC_MAP_REGS_SVH
`define RTC_MAP_REGS_SVH
// ==========================================
// register offsets
`define OFS_CONTROL 4'h0
`define OFS_SYNC_STATUS 4'h1
`define OFS_IRQ_ENABLE 4'h2
`define OFS_IRQ_FLAGS 4'h3
`define OFS_BYTE_LATCH 4'h4
`define OFS_COUNT_LO 4'h8
`define OFS_COUNT_HI 4'h9
`define OFS_LIMIT_LO 4'hA
`define OFS_LIMIT_HI 4'hB
`define OFS_MATCH_LO 4'hC
`define OFS_MATCH_HI 4'hD
// ==========================================
// field positions
`define DIV_FIELD 2:0
`define WRAP_LVL_FIELD 1:0
`define MATCH_LVL_FIELD 3:2
`define IRQ_EN_FIELD 3:0
`define WRAP_FLAG_BIT 0
`define MATCH_FLAG_BIT 1
`define BUSY_BIT 0
// ==========================================
// reset values
`define RST_DIV 3'h0
`define RST_IRQ_EN 4'h0
`define RST_BYTE 8'h00
`define RST_WORD 16'h0000
`define RST_LIMIT 16'hFFFF
`define RST_PRESC 10'h000
// ==========================================
// divider selections and prescaler masks
`define DIV_OFF 3'h0
`define MASK_DIV1 10'h000
`define MASK_DIV2 10'h001
`define MASK_DIV8 10'h007
`define MASK_DIV16 10'h00F
`define MASK_DIV64 10'h03F
`define MASK_DIV256 10'h0FF
`define MASK_DIV1024 10'h3FF
// ==========================================
// misc constants
`define LVL_OFF 2'h0
`define VEC_WRAP 8'h00
`define VEC_MATCH 8'h02
`define GAP_FULL 2'h2
`define GAP_ZERO 2'h0
`define GAP_STEP 2'h1
`define PEND_NONE 4'h0
`endif

//--- rtl/rtc_types_pkg.sv
// types shared by the tick counter register block
package rtc_types_pkg;
	// ==========================================
	// data widths
	typedef logic [7:0] byte_t;
	typedef logic [3:0] addr_t;
	typedef logic [15:0] word_t;
	// ==========================================
	// domain crossing sequencer, gray on every step except SYNC_WAIT2 back to SYNC_IDLE
	typedef enum logic [1:0]
	{
		SYNC_IDLE = 2'h0,
		SYNC_WAIT1 = 2'h1,
		SYNC_WAIT2 = 2'h3
	} sync_state_e;
endpackage : rtc_types_pkg

//--- rtl/async_tick_counter_regs.sv
// register, flag and counter logic of the 16-bit tick counter
//
// Function
// - wrap level field enables wrap request
// - match flag set on count after equality
// - wrap flag set on count after equality
// - match flag cleared by vector or one
// - wrap flag cleared by vector or one
// - low byte write held in latch
// - low byte read captures high byte
// - counter increments on each prescaled tick
// - value updates apply after two slow edges
// - equality with limit wraps counter to zero
// - equality with match value sets match flag
// - match above limit never gives match
// - vector offsets 0x00 wrap, 0x02 match
// - fixed register map offsets
// - divider field selects stop or division
// - busy flag shows pending domain crossing
// - events thinned for limit zero or one
// - match level field enables match request
//
// Strobed register access is this design's own decision.
`timescale 1ns/100ps
`include "rtc_map_regs.svh"

module async_tick_counter_regs
(
	input wire logic sys_clk,
	input wire logic reset,
	input wire logic clk_en,
	input wire logic ref_clk_in,
	input wire rtc_types_pkg::addr_t reg_addr,
	input wire rtc_types_pkg::byte_t reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output rtc_types_pkg::byte_t reg_rdata,
	input wire logic wrap_vector_ack,
	input wire logic match_vector_ack,
	output logic wrap_irq_req,
	output logic [1:0] wrap_irq_level,
	output logic match_irq_req,
	output logic [1:0] match_irq_level,
	output rtc_types_pkg::byte_t irq_vector_offset,
	output logic wrap_event,
	output logic match_event
);
	import rtc_types_pkg::*;

	// ==========================================
	// helper functions
	// address compare used by every decode
	function automatic logic is_addr(input addr_t a, input addr_t t);
		is_addr = (a == t);
	endfunction : is_addr

	// prescaler mask for a divider selection
	function automatic logic [9:0] div_mask(input logic [2:0] d);
		case (d)
			3'h1: div_mask = `MASK_DIV1;
			3'h2: div_mask = `MASK_DIV2;
			3'h3: div_mask = `MASK_DIV8;
			3'h4: div_mask = `MASK_DIV16;
			3'h5: div_mask = `MASK_DIV64;
			3'h6: div_mask = `MASK_DIV256;
			default: div_mask = `MASK_DIV1024;
		endcase
	endfunction : div_mask

	// ==========================================
	// state
	logic [2:0] ctrl_div_reg; // divider as written
	logic [2:0] div_act_reg; // divider in effect
	logic [3:0] irq_en_reg; // both level fields
	logic wrap_flag_reg; // sticky wrap flag
	logic match_flag_reg; // sticky match flag
	byte_t latch_reg; // shared byte latch
	word_t tick_count_reg; // running counter
	word_t count_stage_reg; // counter value waiting to cross
	word_t limit_wr_reg; // limit as written
	word_t limit_act_reg; // limit in effect
	word_t match_wr_reg; // match value as written
	word_t match_act_reg; // match value in effect
	logic [3:0] pend_reg; // pending: div, count, limit, match
	sync_state_e sync_state_reg; // crossing sequencer
	logic ref_prev_reg; // last sample of slow clock
	logic [9:0] presc_reg; // prescaler
	logic [1:0] gap_wrap_reg; // ticks since last wrap event
	logic [1:0] gap_match_reg; // ticks since last match event
	byte_t rdata_reg;
	logic wrap_req_reg;
	logic match_req_reg;
	logic [1:0] wrap_lvl_reg;
	logic [1:0] match_lvl_reg;
	byte_t vec_reg;
	logic wrap_evt_reg;
	logic match_evt_reg;

	// ==========================================
	// bus decode
	wire wr_en = clk_en & reg_wr;
	wire rd_en = clk_en & reg_rd;
	wire wr_ctrl = wr_en & is_addr(reg_addr, `OFS_CONTROL);
	wire wr_irq_en = wr_en & is_addr(reg_addr, `OFS_IRQ_ENABLE);
	wire wr_flags = wr_en & is_addr(reg_addr, `OFS_IRQ_FLAGS);
	wire wr_latch = wr_en & is_addr(reg_addr, `OFS_BYTE_LATCH);
	wire wr_count_hi = wr_en & is_addr(reg_addr, `OFS_COUNT_HI);
	wire wr_limit_hi = wr_en & is_addr(reg_addr, `OFS_LIMIT_HI);
	wire wr_match_hi = wr_en & is_addr(reg_addr, `OFS_MATCH_HI);
	wire wr_low = wr_en & (is_addr(reg_addr, `OFS_COUNT_LO) | is_addr(reg_addr, `OFS_LIMIT_LO)
		| is_addr(reg_addr, `OFS_MATCH_LO));
	wire rd_count_lo = rd_en & is_addr(reg_addr, `OFS_COUNT_LO);
	wire rd_limit_lo = rd_en & is_addr(reg_addr, `OFS_LIMIT_LO);
	wire rd_match_lo = rd_en & is_addr(reg_addr, `OFS_MATCH_LO);
	wire rd_high = is_addr(reg_addr, `OFS_COUNT_HI) | is_addr(reg_addr, `OFS_LIMIT_HI)
		| is_addr(reg_addr, `OFS_MATCH_HI);
	// any write that must cross into the slow domain
	wire wr_sync_any = wr_ctrl | wr_count_hi | wr_limit_hi | wr_match_hi;
	wire [3:0] pend_new = {wr_match_hi, wr_limit_hi, wr_count_hi, wr_ctrl};
	// full 16-bit value from high byte plus latch
	wire word_t wr_word = {reg_wdata, latch_reg};
	wire busy = (sync_state_reg != SYNC_IDLE);

	// ==========================================
	// slow clock edge and prescaler
	// slow clock is sampled as a plain synchronous input
	wire ref_edge = clk_en & ref_clk_in & ~ref_prev_reg;
	wire div_on = (div_act_reg != `DIV_OFF);
	wire presc_hit = ((presc_reg & div_mask(div_act_reg)) == div_mask(div_act_reg));
	wire tick = ref_edge & div_on & presc_hit;
	wire [9:0] presc_next = div_on ? presc_reg + 10'h001 : `RST_PRESC;

	// ==========================================
	// crossing sequencer
	// apply happens on the second slow edge after the last write
	wire apply = ref_edge & (sync_state_reg == SYNC_WAIT2) & ~wr_sync_any;
	sync_state_e sync_next;
	assign sync_next = wr_sync_any ? SYNC_WAIT1 :
		(ref_edge & (sync_state_reg == SYNC_WAIT1)) ? SYNC_WAIT2 :
		apply ? SYNC_IDLE : sync_state_reg;

	// ==========================================
	// compare and flag logic
	wire at_limit = (tick_count_reg == limit_act_reg);
	wire match_legal = (match_act_reg <= limit_act_reg);
	wire wrap_set = tick & at_limit;
	wire match_set = tick & (tick_count_reg == match_act_reg) & match_legal;
	wire wrap_clr = wrap_vector_ack | (wr_flags & reg_wdata[`WRAP_FLAG_BIT]);
	wire match_clr = match_vector_ack | (wr_flags & reg_wdata[`MATCH_FLAG_BIT]);
	// set wins over a clear in the same cycle
	wire wrap_flag_next = wrap_set | (wrap_flag_reg & ~wrap_clr);
	wire match_flag_next = match_set | (match_flag_reg & ~match_clr);

	// ==========================================
	// counter next value
	// count each tick
	wire word_t count_next = (apply & pend_reg[1]) ? count_stage_reg :
		wrap_set ? `RST_WORD :
		tick ? tick_count_reg + 16'h0001 : tick_count_reg;

	// ==========================================
	// event thinning
	// spacing of at least three ticks
	wire wrap_evt_next = wrap_set & (gap_wrap_reg == `GAP_FULL);
	wire match_evt_next = match_set & (gap_match_reg == `GAP_FULL);
	wire [1:0] gap_wrap_next = wrap_evt_next ? `GAP_ZERO :
		(gap_wrap_reg == `GAP_FULL) ? `GAP_FULL : gap_wrap_reg + `GAP_STEP;
	wire [1:0] gap_match_next = match_evt_next ? `GAP_ZERO :
		(gap_match_reg == `GAP_FULL) ? `GAP_FULL : gap_match_reg + `GAP_STEP;

	// ==========================================
	// byte latch
	// hold low byte
	wire byte_t latch_next = (wr_low | wr_latch) ? reg_wdata :
		rd_count_lo ? tick_count_reg[15:8] :
		rd_limit_lo ? limit_wr_reg[15:8] :
		rd_match_lo ? match_wr_reg[15:8] : latch_reg;

	// ==========================================
	// read mux, reserved bits read zero
	// register map
	wire byte_t rd_mux =
		is_addr(reg_addr, `OFS_CONTROL) ? {5'h00, ctrl_div_reg} :
		is_addr(reg_addr, `OFS_SYNC_STATUS) ? {7'h00, busy} :
		is_addr(reg_addr, `OFS_IRQ_ENABLE) ? {4'h0, irq_en_reg} :
		is_addr(reg_addr, `OFS_IRQ_FLAGS) ? {6'h00, match_flag_reg, wrap_flag_reg} :
		is_addr(reg_addr, `OFS_BYTE_LATCH) ? latch_reg :
		is_addr(reg_addr, `OFS_COUNT_LO) ? tick_count_reg[7:0] :
		is_addr(reg_addr, `OFS_LIMIT_LO) ? limit_wr_reg[7:0] :
		is_addr(reg_addr, `OFS_MATCH_LO) ? match_wr_reg[7:0] :
		rd_high ? latch_reg : `RST_BYTE;

	// ==========================================
	// interrupt request terms
	// wrap request
	wire wrap_req_next = wrap_flag_reg & (irq_en_reg[`WRAP_LVL_FIELD] != `LVL_OFF);
	wire match_req_next = match_flag_reg & (irq_en_reg[`MATCH_LVL_FIELD] != `LVL_OFF);
	wire byte_t vec_next = wrap_req_next ? `VEC_WRAP : `VEC_MATCH;

	// ==========================================
	// software side registers
	always_ff @(posedge sys_clk)
	begin
		if (reset)
		begin
			ctrl_div_reg <= `RST_DIV;
			irq_en_reg <= `RST_IRQ_EN;
			latch_reg <= `RST_BYTE;
			count_stage_reg <= `RST_WORD;
			limit_wr_reg <= `RST_LIMIT;
			match_wr_reg <= `RST_WORD;
		end
		else if (clk_en)
		begin
			if (wr_ctrl)
				ctrl_div_reg <= reg_wdata[`DIV_FIELD];
			if (wr_irq_en)
				irq_en_reg <= reg_wdata[`IRQ_EN_FIELD];
			latch_reg <= latch_next;
			if (wr_count_hi)
				count_stage_reg <= wr_word;
			if (wr_limit_hi)
				limit_wr_reg <= wr_word;
			if (wr_match_hi)
				match_wr_reg <= wr_word;
		end
	end

	// ==========================================
	// crossing: pending set and applied values
	// busy while pending
	always_ff @(posedge sys_clk)
	begin
		if (reset)
		begin
			sync_state_reg <= SYNC_IDLE;
			pend_reg <= `PEND_NONE;
			div_act_reg <= `RST_DIV;
			limit_act_reg <= `RST_LIMIT;
			match_act_reg <= `RST_WORD;
		end
		else if (clk_en)
		begin
			sync_state_reg <= sync_next;
			pend_reg <= apply ? `PEND_NONE : (pend_reg | pend_new);
			if (apply & pend_reg[0])
				div_act_reg <= ctrl_div_reg;
			if (apply & pend_reg[2])
				limit_act_reg <= limit_wr_reg;
			if (apply & pend_reg[3])
				match_act_reg <= match_wr_reg;
		end
	end

	// ==========================================
	// counting side
	always_ff @(posedge sys_clk)
	begin
		if (reset)
		begin
			ref_prev_reg <= 1'b0;
			presc_reg <= `RST_PRESC;
			tick_count_reg <= `RST_WORD;
			gap_wrap_reg <= `GAP_FULL;
			gap_match_reg <= `GAP_FULL;
			wrap_flag_reg <= 1'b0;
			match_flag_reg <= 1'b0;
		end
		else if (clk_en)
		begin
			ref_prev_reg <= ref_clk_in;
			if (ref_edge)
				presc_reg <= presc_next;
			tick_count_reg <= count_next;
			if (tick)
			begin
				gap_wrap_reg <= gap_wrap_next;
				gap_match_reg <= gap_match_next;
			end
			wrap_flag_reg <= wrap_flag_next;
			match_flag_reg <= match_flag_next;
		end
	end

	// ==========================================
	// registered outputs
	always_ff @(posedge sys_clk)
	begin
		if (reset)
		begin
			rdata_reg <= `RST_BYTE;
			wrap_req_reg <= 1'b0;
			match_req_reg <= 1'b0;
			wrap_lvl_reg <= `LVL_OFF;
			match_lvl_reg <= `LVL_OFF;
			vec_reg <= `VEC_WRAP;
			wrap_evt_reg <= 1'b0;
			match_evt_reg <= 1'b0;
		end
		else if (clk_en)
		begin
			rdata_reg <= rd_en ? rd_mux : `RST_BYTE;
			wrap_req_reg <= wrap_req_next;
			match_req_reg <= match_req_next;
			wrap_lvl_reg <= irq_en_reg[`WRAP_LVL_FIELD];
			match_lvl_reg <= irq_en_reg[`MATCH_LVL_FIELD];
			vec_reg <= vec_next;
			wrap_evt_reg <= wrap_evt_next;
			match_evt_reg <= match_evt_next;
		end
	end

	assign reg_rdata = rdata_reg;
	assign wrap_irq_req = wrap_req_reg;
	assign match_irq_req = match_req_reg;
	assign wrap_irq_level = wrap_lvl_reg;
	assign match_irq_level = match_lvl_reg;
	assign irq_vector_offset = vec_reg;
	assign wrap_event = wrap_evt_reg;
	assign match_event = match_evt_reg;

	// ==========================================
	// checks
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (reset || !clk_en);

	sequence s_second_edge;
		(sync_state_reg == SYNC_WAIT2) && ref_edge && !wr_sync_any;
	endsequence
	sequence s_applied;
		!busy && (pend_reg == `PEND_NONE);
	endsequence

	AST_WRAP_REQ: assert property (wrap_flag_reg && irq_en_reg[1:0] != 2'h0 |=> wrap_irq_req)
		else $error("wrap request missing");
	AST_MATCH_SET: assert property (tick && tick_count_reg == match_act_reg && match_legal
		|=> match_flag_reg)
		else $error("match flag not set");
	AST_WRAP_SET: assert property (tick && at_limit |=> wrap_flag_reg && tick_count_reg == 16'h0000)
		else $error("wrap flag or counter reset wrong");
	AST_MATCH_CLR: assert property (match_vector_ack && !match_set |=> !match_flag_reg)
		else $error("match flag not cleared");
	AST_WRAP_W1C: assert property (wr_flags && reg_wdata[0] && !wrap_set |=> !wrap_flag_reg)
		else $error("wrap flag not cleared by one");
	AST_LATCH_WR: assert property (wr_low |=> latch_reg == $past(reg_wdata))
		else $error("low byte not latched");
	AST_LATCH_RD: assert property (rd_count_lo |=> latch_reg == $past(tick_count_reg[15:8]))
		else $error("high byte not captured");
	AST_SYNC_DONE: assert property (s_second_edge |=> s_applied)
		else $error("update not applied on second edge");
	AST_BUSY_SET: assert property (wr_sync_any |=> busy ##0 reg_rdata == 8'h00 [*1])
		else $error("busy not raised");
	AST_NO_MATCH: assert property (match_act_reg > limit_act_reg && !match_flag_reg
		|=> !match_flag_reg)
		else $error("match above limit");
	AST_DIV_OFF: assert property (div_act_reg == `DIV_OFF && !apply |=> tick_count_reg == $past(tick_count_reg))
		else $error("tick while stopped");
	AST_EVT_GAP: assert property (wrap_event |=> !wrap_event [*2])
		else $error("wrap events too close");
	AST_LVL_OFF: assert property (irq_en_reg[3:2] == 2'h0 |=> !match_irq_req)
		else $error("masked match request");

endmodule : async_tick_counter_regs

//--- tb/testbench.sv
// self-checking bench of the tick counter register block
`timescale 1ns/100ps
`include "rtc_map_regs.svh"

module testbench;
	import rtc_types_pkg::*;
	// ==========================================
	// bench signals
	localparam int REF_PER = 4; // system cycles per reference period
	logic sys_clk;
	logic reset;
	logic clk_en; // clock enable of the device
	logic ref_clk_in;
	addr_t reg_addr;
	byte_t reg_wdata;
	logic reg_wr;
	logic reg_rd;
	byte_t reg_rdata;
	logic wrap_vector_ack;
	logic match_vector_ack;
	logic wrap_irq_req;
	logic [1:0] wrap_irq_level;
	logic match_irq_req;
	logic [1:0] match_irq_level;
	byte_t irq_vector_offset;
	logic wrap_event;
	logic match_event;
	int num_errors = 0; // mismatches seen
	int checks_done = 0; // comparisons made
	int match_pulses = 0; // match events observed
	int mp0; // match events before the spacing loop
	logic [31:0] seed;
	byte_t rb;
	word_t rw;
	int gap;
	int divs[9] = '{1, 1, 1, 2, 3, 4, 5, 6, 7}; // divider codes under test
	int lims[9] = '{0, 1, 2, 2, 2, 2, 2, 2, 0}; // limits under test

	// ==========================================
	// device under test
	async_tick_counter_regs i_dut
	(
		.sys_clk(sys_clk),
		.reset(reset),
		.clk_en(clk_en),
		.ref_clk_in(ref_clk_in),
		.reg_addr(reg_addr),
		.reg_wdata(reg_wdata),
		.reg_wr(reg_wr),
		.reg_rd(reg_rd),
		.reg_rdata(reg_rdata),
		.wrap_vector_ack(wrap_vector_ack),
		.match_vector_ack(match_vector_ack),
		.wrap_irq_req(wrap_irq_req),
		.wrap_irq_level(wrap_irq_level),
		.match_irq_req(match_irq_req),
		.match_irq_level(match_irq_level),
		.irq_vector_offset(irq_vector_offset),
		.wrap_event(wrap_event),
		.match_event(match_event)
	);

	// ==========================================
	// clocks
	initial
	begin
		sys_clk = 1'b0;
		forever #4 sys_clk = ~sys_clk;
	end
	// slow reference, free running, steady phase
	initial
	begin
		ref_clk_in = 1'b0;
		forever
		begin
			repeat (REF_PER / 2) @(posedge sys_clk);
			ref_clk_in <= ~ref_clk_in;
		end
	end
	// count match event pulses
	always @(posedge sys_clk)
		if (match_event === 1'b1)
			match_pulses <= match_pulses + 1;

	// ==========================================
	// helpers
	// next xorshift value
	function automatic logic [31:0] xs(input logic [31:0] x);
		logic [31:0] y;
		y = x ^ (x << 13);
		y = y ^ (y >> 17);
		xs = y ^ (y << 5);
	endfunction : xs
	// expected cycles between wrap events
	function automatic int exp_gap(input int dsel, input int lim);
		int dv[8] = '{0, 1, 2, 8, 16, 64, 256, 1024};
		int ticks;
		ticks = (lim == 0) ? 3 : (lim == 1) ? 4 : lim + 1;
		exp_gap = dv[dsel] * REF_PER * ticks;
	endfunction : exp_gap
	// compare and count
	task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
		checks_done++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("[FAIL] %0t %s seen %h expected %h", $time, what, seen, exp);
		end
	endtask : check
	// one write cycle
	task automatic wr(input addr_t a, input byte_t d);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask : wr
	// one read cycle, data taken in the following cycle
	task automatic rd(input addr_t a, output byte_t d);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1;
		d = reg_rdata;
	endtask : rd
	// low byte first, then high byte
	task automatic wr16(input addr_t a, input word_t v);
		wr(a, v[7:0]);
		wr(a + 4'h1, v[15:8]);
	endtask : wr16
	task automatic rd16(input addr_t a, output word_t v);
		byte_t lo;
		byte_t hi;
		rd(a, lo);
		rd(a + 4'h1, hi);
		v = {hi, lo};
	endtask : rd16
	// poll busy under a bound
	task automatic wait_idle();
		byte_t s;
		int n;
		n = 0;
		s = 8'h01;
		while (s[`BUSY_BIT] !== 1'b0 && n < 50)
		begin
			rd(`OFS_SYNC_STATUS, s);
			n++;
		end
		check(s, 8'h00, "busy clear");
	endtask : wait_idle
	// cycles up to the next wrap event
	task automatic wait_ev(output int n);
		n = 0;
		do
		begin
			@(posedge sys_clk);
			#1;
			n++;
		end
		while (wrap_event !== 1'b1 && n < 40000);
	endtask : wait_ev
	// vector acknowledge pulse
	task automatic ack(input logic w);
		@(posedge sys_clk);
		wrap_vector_ack <= w;
		match_vector_ack <= ~w;
		@(posedge sys_clk);
		wrap_vector_ack <= 1'b0;
		match_vector_ack <= 1'b0;
	endtask : ack
	// run at full rate for a while, then stop
	task automatic run(input byte_t ien);
		wr(`OFS_IRQ_ENABLE, ien);
		wr(`OFS_CONTROL, 8'h01);
		wait_idle();
		repeat (100) @(posedge sys_clk);
		wr(`OFS_CONTROL, 8'h00);
		wait_idle();
	endtask : run
	// verdict
	task automatic test_done();
		$display("checks %0d mismatches %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : test_done

	// ==========================================
	// watchdog
	initial
	begin
		repeat (70000) @(posedge sys_clk);
		num_errors++;
		$display("[FAIL] %0t watchdog expired", $time);
		test_done();
	end

	// ==========================================
	// main sequence
	initial
	begin
		reset = 1'b1;
		clk_en = 1'b1;
		reg_addr = 4'h0;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		wrap_vector_ack = 1'b0;
		match_vector_ack = 1'b0;
		seed = 32'h90b3;
		repeat (4) @(posedge sys_clk);
		reset <= 1'b0;
		// reset values, holes read zero
		for (int i = 0; i < 16; i++)
		begin
			rd(addr_t'(i), rb);
			check(rb, (i == 10 || i == 11) ? 8'hFF : 8'h00, "reset read");
		end
		$display("test reset done");
		// random enables and latch, status write ignored
		repeat (4)
		begin
			seed = xs(seed);
			wr(`OFS_IRQ_ENABLE, {4'h0, seed[3:0]});
			wr(`OFS_BYTE_LATCH, seed[15:8]);
			wr(`OFS_SYNC_STATUS, {7'h00, seed[16]});
			rd(`OFS_IRQ_ENABLE, rb);
			check(rb, {4'h0, seed[3:0]}, "irq enable");
			check({match_irq_level, wrap_irq_level}, seed[3:0], "levels");
			rd(`OFS_BYTE_LATCH, rb);
			check(rb, seed[15:8], "latch");
			rd(`OFS_SYNC_STATUS, rb);
			check(rb, 8'h00, "status");
		end
		$display("test access done");
		// paired values through the latch, delayed count load
		wr16(`OFS_LIMIT_LO, 16'h0005);
		rd(`OFS_SYNC_STATUS, rb);
		check(rb, 8'h01, "busy set");
		wait_idle();
		rd16(`OFS_LIMIT_LO, rw);
		check(rw, 16'h0005, "limit");
		wr16(`OFS_MATCH_LO, 16'h0003);
		wait_idle();
		seed = xs(seed);
		wr16(`OFS_COUNT_LO, seed[15:0]);
		rd16(`OFS_COUNT_LO, rw);
		check(rw, 16'h0000, "count before sync");
		wait_idle();
		rd16(`OFS_COUNT_LO, rw);
		check(rw, seed[15:0], "count after sync");
		wr16(`OFS_COUNT_LO, 16'h0000);
		wait_idle();
		$display("test pairs done");
		// flags, requests, vectors and clearing
		run(8'h05);
		#1;
		check({wrap_irq_req, match_irq_req, irq_vector_offset}, 10'h300, "both pending");
		rd16(`OFS_COUNT_LO, rw);
		check(rw <= 16'h0005, 1'b1, "count within limit");
		wr(`OFS_IRQ_FLAGS, 8'h00);
		rd(`OFS_IRQ_FLAGS, rb);
		check(rb, 8'h03, "flags set");
		ack(1'b1);
		rd(`OFS_IRQ_FLAGS, rb);
		check(rb, 8'h02, "wrap ack");
		check({wrap_irq_req, irq_vector_offset}, 9'h002, "match vector");
		wr(`OFS_IRQ_FLAGS, 8'h02);
		rd(`OFS_IRQ_FLAGS, rb);
		check(rb, 8'h00, "match w1c");
		run(8'h05);
		ack(1'b0);
		rd(`OFS_IRQ_FLAGS, rb);
		check(rb, 8'h01, "match ack");
		wr(`OFS_IRQ_FLAGS, 8'h01);
		rd(`OFS_IRQ_FLAGS, rb);
		check(rb, 8'h00, "wrap w1c");
		// level zero masks the match request
		run(8'h01);
		#1;
		check({wrap_irq_req, match_irq_req}, 2'b10, "masked match");
		wr(`OFS_IRQ_FLAGS, 8'h03);
		// match above limit stays silent
		wr16(`OFS_MATCH_LO, 16'h0009);
		wait_idle();
		gap = match_pulses;
		run(8'h05);
		rd(`OFS_IRQ_FLAGS, rb);
		check(rb, 8'h01, "match above limit");
		check(match_pulses, gap, "no match event");
		$display("test flags done");
		// match at zero so match events appear in the loop
		wr16(`OFS_MATCH_LO, 16'h0000);
		wait_idle();
		mp0 = match_pulses;
		// event spacing per divider and limit
		for (int k = 0; k < 9; k++)
		begin
			wr(`OFS_CONTROL, 8'h00);
			wait_idle();
			wr16(`OFS_COUNT_LO, 16'h0000);
			wait_idle();
			wr16(`OFS_LIMIT_LO, word_t'(lims[k]));
			wait_idle();
			wr(`OFS_CONTROL, byte_t'(divs[k]));
			wait_idle();
			wait_ev(gap);
			wait_ev(gap);
			wait_ev(gap);
			check(gap, exp_gap(divs[k], lims[k]), "event spacing");
		end
		check(match_pulses > mp0, 1'b1, "match events");
		// clock enable low freezes counting and outputs
		wr(`OFS_CONTROL, 8'h01);
		wait_idle();
		wait_ev(gap);
		@(posedge sys_clk);
		clk_en <= 1'b0;
		gap = 0;
		repeat (24)
		begin
			@(posedge sys_clk);
			#1;
			if (wrap_event === 1'b1)
				gap++;
		end
		check(gap, 0, "frozen events");
		@(posedge sys_clk);
		clk_en <= 1'b1;
		// divider zero holds the count
		wr(`OFS_CONTROL, 8'h00);
		wait_idle();
		rd16(`OFS_COUNT_LO, rw);
		repeat (50) @(posedge sys_clk);
		rd16(`OFS_COUNT_LO, seed[15:0]);
		check(seed[15:0], rw, "stopped count");
		$display("test events done");
		test_done();
	end
endmodule : testbench
